//--- ofx_pkg.sv
// Purpose: Shared constants and types for the operand-format and transfer unit
// Assumes: 16-bit address space, byte-wide memory lanes, big-endian words
// Notes: Operation and addressing-mode codes are local to this block
package ofx_pkg;
	localparam logic [15:0] SHORT_PAGE_BASE = 16'hff00;
	localparam logic [2:0] STACK_REG_IDX = 3'h7;
	localparam logic [15:0] BYTE_STEP = 16'h0001;
	localparam logic [15:0] WORD_STEP = 16'h0002;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam int BCD_LO_MSB = 3;
	localparam int BCD_HI_LSB = 4;

	typedef enum logic [3:0]
	{
		OFX_OP_TRANSFER,
		OFX_OP_PUSH,
		OFX_OP_POP,
		OFX_OP_DEC_ADJ_ADD,
		OFX_OP_DEC_ADJ_SUB,
		OFX_OP_WORD_SMALL_INC,
		OFX_OP_WORD_SMALL_DEC,
		OFX_OP_BIT_SET,
		OFX_OP_BIT_CLR,
		OFX_OP_FLAGS_PUSH,
		OFX_OP_FLAGS_POP,
		OFX_OP_PERIPH_OUT,
		OFX_OP_PERIPH_IN
	} ofx_op_e;

	typedef enum logic [2:0]
	{
		OFX_AM_REG,
		OFX_AM_IND,
		OFX_AM_DISP,
		OFX_AM_ABS16,
		OFX_AM_ABS8,
		OFX_AM_IMM,
		OFX_AM_PREDEC,
		OFX_AM_POSTINC
	} ofx_am_e;
endpackage : ofx_pkg

//--- ofx_transfer_unit.sv
// Purpose: Operand formatting, data transfer and stack moves of the CPU core
// Assumes: Single-cycle memory answer (memRdata valid while the read request stands)
// Notes: Register file holds eight 16-bit registers; half select picks upper or lower byte
`timescale 1ns/1ns
module ofx_transfer_unit
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Operation request
	input wire logic opValid,
	input wire ofx_pkg::ofx_op_e opCode,
	input wire ofx_pkg::ofx_am_e addrMode,
	input wire logic opWord,
	input wire logic [2:0] regDst,
	input wire logic regDstUpper,
	input wire logic [2:0] regSrc,
	input wire logic regSrcUpper,
	input wire logic [15:0] extWord,
	input wire logic [2:0] bitNum,
	input wire logic halfCarry,
	input wire logic carryIn,
	// Memory bus
	output logic memReq,
	output logic memWrite,
	output logic memWord,
	output logic [15:0] memAddr,
	output logic [15:0] memWdata,
	input wire logic [15:0] memRdata,
	// Status
	output logic [7:0] condFlags,
	output logic opDone,
	output logic opIllegal
);
	typedef enum logic [1:0] {ST_IDLE, ST_READ} ofx_state_e;

	logic [15:0] regFile [8];
	ofx_state_e state_q;
	logic [2:0] ldReg_q;
	logic ldUpper_q;
	logic ldWord_q;
	logic ldFlags_q;
	logic memReq_q, memWrite_q, memWord_q, opDone_q, opIllegal_q;
	logic [15:0] memAddr_q, memWdata_q;
	logic [7:0] condFlags_q;

	// Operand views
	wire logic [15:0] srcWord = regFile[regSrc];
	wire logic [15:0] dstWord = regFile[regDst];
	wire logic [7:0] srcByte = regSrcUpper ? srcWord[15:8] : srcWord[7:0];
	wire logic [7:0] dstByte = regDstUpper ? dstWord[15:8] : dstWord[7:0];
	wire logic [3:0] dstLoDigit = dstByte[ofx_pkg::BCD_LO_MSB:0];
	wire logic [3:0] dstHiDigit = dstByte[7:ofx_pkg::BCD_HI_LSB];

	// Classification
	wire logic isPeriph = opCode == ofx_pkg::OFX_OP_PERIPH_OUT || opCode == ofx_pkg::OFX_OP_PERIPH_IN;
	wire logic isPush = opCode == ofx_pkg::OFX_OP_PUSH;
	wire logic isPop = opCode == ofx_pkg::OFX_OP_POP;
	wire logic isFlagPush = opCode == ofx_pkg::OFX_OP_FLAGS_PUSH;
	wire logic isFlagPop = opCode == ofx_pkg::OFX_OP_FLAGS_POP;
	wire logic isXfer = opCode == ofx_pkg::OFX_OP_TRANSFER;
	wire logic isSmall = opCode == ofx_pkg::OFX_OP_WORD_SMALL_INC || opCode == ofx_pkg::OFX_OP_WORD_SMALL_DEC;
	wire logic stackOp = isPush || isPop || isFlagPush || isFlagPop;
	// Stack ops and small inc/dec are word-only
	wire logic effWord = opWord || stackOp || isSmall;
	wire logic xferPre = isXfer && addrMode == ofx_pkg::OFX_AM_PREDEC;
	wire logic xferPost = isXfer && addrMode == ofx_pkg::OFX_AM_POSTINC;
	wire logic useDec = xferPre || isPush || isFlagPush;
	wire logic useInc = xferPost || isPop || isFlagPop;
	wire logic [2:0] ptrIdx = stackOp ? ofx_pkg::STACK_REG_IDX : regSrc;
	wire logic [15:0] ptrVal = regFile[ptrIdx];
	wire logic [15:0] stepVal = effWord ? ofx_pkg::WORD_STEP : ofx_pkg::BYTE_STEP;
	wire logic [15:0] ptrDec = ptrVal - stepVal;
	wire logic [15:0] ptrInc = ptrVal + stepVal;
	wire logic illegalShort = isXfer && addrMode == ofx_pkg::OFX_AM_ABS8 && opWord;
	wire logic illegal = opValid && (isPeriph || illegalShort);

	// Effective address before word alignment
	logic [15:0] rawAddr;
	always_comb
	begin
		rawAddr = ptrVal;
		if (useDec)
			rawAddr = ptrDec;
		else if (isXfer && addrMode == ofx_pkg::OFX_AM_DISP)
			rawAddr = ptrVal + extWord;
		else if (isXfer && addrMode == ofx_pkg::OFX_AM_ABS16)
			rawAddr = extWord;
		else if (isXfer && addrMode == ofx_pkg::OFX_AM_ABS8)
			rawAddr = ofx_pkg::SHORT_PAGE_BASE | {8'h00, extWord[7:0]};
	end
	// Odd word address silently aligned down, no error
	wire logic [15:0] effAddr = effWord ? {rawAddr[15:1], 1'b0} : rawAddr;

	// Memory direction: pushes and pre-decrement transfers store; pops and other memory-mode transfers load
	wire logic memMode = addrMode != ofx_pkg::OFX_AM_REG && addrMode != ofx_pkg::OFX_AM_IMM;
	wire logic doStore = opValid && !illegal && (isPush || isFlagPush || xferPre);
	wire logic doLoad = opValid && !illegal && (isPop || isFlagPop || (isXfer && memMode && !xferPre));
	wire logic [15:0] storeData = isFlagPush ? {condFlags_q, condFlags_q}
		: (effWord ? srcWord : {srcByte, srcByte});

	// Decimal adjust of packed BCD byte
	wire logic [7:0] adjAdd = dstByte + {(carryIn || dstHiDigit > 4'h9 || (dstHiDigit == 4'h9 && dstLoDigit > 4'h9))
		? 4'h6 : 4'h0, (halfCarry || dstLoDigit > 4'h9) ? 4'h6 : 4'h0};
	wire logic [7:0] adjSub = dstByte - {carryIn ? 4'h6 : 4'h0, halfCarry ? 4'h6 : 4'h0};
	wire logic [7:0] bitMask = 8'h01 << bitNum;

	// Register-side result
	logic regWe;
	logic [7:0] resByte;
	logic [15:0] resWord;
	always_comb
	begin
		regWe = 1'b0;
		resByte = dstByte;
		resWord = dstWord;
		if (opValid && !illegal)
		begin
			case (opCode)
				ofx_pkg::OFX_OP_TRANSFER:
				begin
					regWe = !memMode;
					resByte = addrMode == ofx_pkg::OFX_AM_IMM ? extWord[7:0] : srcByte;
					resWord = addrMode == ofx_pkg::OFX_AM_IMM ? extWord : srcWord;
				end
				ofx_pkg::OFX_OP_DEC_ADJ_ADD: begin regWe = 1'b1; resByte = adjAdd; end
				ofx_pkg::OFX_OP_DEC_ADJ_SUB: begin regWe = 1'b1; resByte = adjSub; end
				ofx_pkg::OFX_OP_WORD_SMALL_INC: begin regWe = 1'b1; resWord = dstWord + (bitNum[1] ? ofx_pkg::WORD_STEP : ofx_pkg::BYTE_STEP); end
				ofx_pkg::OFX_OP_WORD_SMALL_DEC: begin regWe = 1'b1; resWord = dstWord - (bitNum[1] ? ofx_pkg::WORD_STEP : ofx_pkg::BYTE_STEP); end
				ofx_pkg::OFX_OP_BIT_SET: begin regWe = 1'b1; resByte = dstByte | bitMask; end
				ofx_pkg::OFX_OP_BIT_CLR: begin regWe = 1'b1; resByte = dstByte & ~bitMask; end
				default: regWe = 1'b0;
			endcase
		end
	end
	wire logic regIsWord = effWord;
	wire logic ptrWe = opValid && !illegal && (useDec || useInc) && state_q == ST_IDLE;
	wire logic [15:0] ptrNext = useDec ? ptrDec : ptrInc;
	wire logic [15:0] loadWord = memRdata;
	wire logic [15:0] loadMerged = ldUpper_q ? {memRdata[15:8], regFile[ldReg_q][7:0]} : {regFile[ldReg_q][15:8], memRdata[15:8]};

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			for (int i = 0; i < 8; i++)
				regFile[i] <= ofx_pkg::REG_RESET;
		end
		else
		begin
			if (state_q == ST_READ && !ldFlags_q)
				regFile[ldReg_q] <= ldWord_q ? loadWord : loadMerged;
			else if (state_q == ST_IDLE && regWe)
				regFile[regDst] <= regIsWord ? resWord : (regDstUpper ? {resByte, dstWord[7:0]} : {dstWord[15:8], resByte});
			if (ptrWe)
				regFile[ptrIdx] <= ptrNext;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state_q <= ST_IDLE;
			memReq_q <= 1'b0;
			memWrite_q <= 1'b0;
			memWord_q <= 1'b0;
			memAddr_q <= 16'h0000;
			memWdata_q <= 16'h0000;
			condFlags_q <= 8'h80;
			opDone_q <= 1'b0;
			opIllegal_q <= 1'b0;
			ldReg_q <= 3'h0;
			ldUpper_q <= 1'b0;
			ldWord_q <= 1'b0;
			ldFlags_q <= 1'b0;
		end
		else
		begin
			memReq_q <= 1'b0;
			memWrite_q <= 1'b0;
			opDone_q <= 1'b0;
			opIllegal_q <= illegal && state_q == ST_IDLE;
			case (state_q)
				ST_IDLE:
				begin
					if (doStore || doLoad)
					begin
						memReq_q <= 1'b1;
						memWrite_q <= doStore;
						memWord_q <= effWord;
						memAddr_q <= effAddr;
						memWdata_q <= storeData;
						ldReg_q <= regDst;
						ldUpper_q <= regDstUpper;
						ldWord_q <= effWord;
						ldFlags_q <= isFlagPop;
						state_q <= doLoad ? ST_READ : ST_IDLE;
						opDone_q <= doStore;
					end
					else
						opDone_q <= opValid && !illegal;
				end
				ST_READ:
				begin
					if (ldFlags_q)
						condFlags_q <= memRdata[15:8];
					opDone_q <= 1'b1;
					state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	assign memReq = memReq_q;
	assign memWrite = memWrite_q;
	assign memWord = memWord_q;
	assign memAddr = memAddr_q;
	assign memWdata = memWdata_q;
	assign condFlags = condFlags_q;
	assign opDone = opDone_q;
	assign opIllegal = opIllegal_q;

	AST_WORD_EVEN: assert property (@(posedge core_clk) disable iff (rst) memReq && memWord |-> !memAddr[0])
		else $error("word access at odd address");
	AST_FLAG_DUP: assert property (@(posedge core_clk) disable iff (rst)
		opValid && isFlagPush && state_q == ST_IDLE |=> memWdata[15:8] == memWdata[7:0])
		else $error("flag byte not duplicated");
	AST_FLAG_POP: assert property (@(posedge core_clk) disable iff (rst)
		state_q == ST_READ && ldFlags_q |=> condFlags == $past(memRdata[15:8]))
		else $error("flags not taken from upper byte");
	AST_PERIPH_REFUSED: assert property (@(posedge core_clk) disable iff (rst)
		opValid && isPeriph && state_q == ST_IDLE |=> opIllegal && !memReq)
		else $error("peripheral transfer not refused");
	AST_SHORT_PAGE: assert property (@(posedge core_clk) disable iff (rst)
		opValid && isXfer && addrMode == ofx_pkg::OFX_AM_ABS8 && !opWord && state_q == ST_IDLE
		|=> memAddr[15:8] == 8'hff)
		else $error("short address not in top page");
	AST_SHORT_WORD: assert property (@(posedge core_clk) disable iff (rst)
		opValid && illegalShort && state_q == ST_IDLE |=> opIllegal)
		else $error("word short absolute accepted");
	AST_PUSH_DEC: assert property (@(posedge core_clk) disable iff (rst)
		opValid && isPush && state_q == ST_IDLE |=> memWrite && regFile[7] == $past(regFile[7]) - 16'h0002)
		else $error("push did not pre-decrement by two");
	// Pop: read issued with stack register stepped up by a word, then completion
	sequence popIssueSeq;
		memReq && !memWrite && memWord && state_q == ST_READ
			&& regFile[ofx_pkg::STACK_REG_IDX] == $past(regFile[ofx_pkg::STACK_REG_IDX]) + ofx_pkg::WORD_STEP;
	endsequence
	sequence popFinishSeq;
		opDone && state_q == ST_IDLE;
	endsequence
	AST_POP_INC: assert property (@(posedge core_clk) disable iff (rst)
		opValid && isPop && state_q == ST_IDLE |=> popIssueSeq ##1 popFinishSeq)
		else $error("pop sequence broken");
endmodule : ofx_transfer_unit

//--- ofx_mem_model.sv
// Purpose: Byte-wide memory on the far side of the transfer unit's bus
// Assumes: Read data stands while memReq is high, sampled at the edge that ends it
// Notes: Outside answers the read lines toggle, so stale data never matches
`timescale 1ns/1ns
module ofx_mem_model
(
	// Clock
	input wire logic core_clk,
	// Bus from the unit
	input wire logic memReq,
	input wire logic memWrite,
	input wire logic memWord,
	input wire logic [15:0] memAddr,
	input wire logic [15:0] memWdata,
	output logic [15:0] memRdata
);
	logic [7:0] mem [0:65535];
	logic [15:0] idleRd_q;
	initial
	begin
		idleRd_q = 16'h0000;
		for (int i = 0; i < 65536; i++)
			mem[i] = i[7:0] ^ 8'h5a;
	end
	// Read answers within the request cycle; idle lines show the inverse of the last value
	assign memRdata = (memReq === 1'b1 && memWrite === 1'b0)
		? {mem[memAddr], mem[memAddr + {15'h0000, memWord}]} : ~idleRd_q;
	always @(posedge core_clk)
	begin
		if (memReq && memWrite)
		begin
			mem[memAddr] <= memWdata[15:8];
			if (memWord)
				mem[memAddr + 16'h0001] <= memWdata[7:0];
		end
		idleRd_q <= memRdata;
	end
endmodule : ofx_mem_model

//--- tb.sv
// Purpose: Self-checking bench of the transfer unit
// Assumes: Driver notes expected accesses; observer pops one per result
// Notes: regSrc and regDst are always driven alike
`timescale 1ns/1ns
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin err_total++; $display("MISMATCH %0t %s", $time, m); end end
module tb;
	logic core_clk = 1'b0, rst = 1'b1, opValid = 1'b0, opWord = 1'b0, halfCarry = 1'b0, carryIn = 1'b0;
	logic regDstUpper = 1'b0, regSrcUpper = 1'b0;
	ofx_pkg::ofx_op_e opCode = ofx_pkg::OFX_OP_TRANSFER;
	ofx_pkg::ofx_am_e addrMode = ofx_pkg::OFX_AM_REG;
	logic [2:0] regDst = 3'h0, regSrc = 3'h0, bitNum = 3'h0;
	logic [15:0] extWord = 16'h0000, memAddr, memWdata, memRdata, sp, v, a, b;
	logic [7:0] t;
	logic [6:0] f;
	logic memReq, memWrite, memWord, opDone, opIllegal;
	logic [7:0] condFlags;
	logic [34:0] expQ [$];
	logic [34:0] e;
	logic [31:0] seed = 32'hd99e67bf;
	int err_total = 0, checks = 0;
	always #4 core_clk = ~core_clk;
	ofx_transfer_unit uut (.core_clk(core_clk), .rst(rst), .opValid(opValid), .opCode(opCode),
		.addrMode(addrMode), .opWord(opWord), .regDst(regDst), .regDstUpper(regDstUpper), .regSrc(regSrc),
		.regSrcUpper(regSrcUpper), .extWord(extWord), .bitNum(bitNum), .halfCarry(halfCarry), .carryIn(carryIn),
		.memReq(memReq), .memWrite(memWrite), .memWord(memWord), .memAddr(memAddr), .memWdata(memWdata),
		.memRdata(memRdata), .condFlags(condFlags), .opDone(opDone), .opIllegal(opIllegal));
	ofx_mem_model mem (.core_clk(core_clk), .memReq(memReq), .memWrite(memWrite), .memWord(memWord),
		.memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata));
	task automatic tally_and_finish();
		if (err_total == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	task automatic exp(input logic ill, input logic wr, input logic wd, input logic [15:0] ad, input logic [15:0] d);
		expQ.push_back({ill, wr, wd, ad, d});
	endtask : exp
	task automatic op(input ofx_pkg::ofx_op_e c, input ofx_pkg::ofx_am_e m, input logic w, input logic [2:0] r,
		input logic [15:0] x);
		int n;
		logic [31:0] q;
		q = $random(seed);
		f = q[6:0];
		@(posedge core_clk);
		opValid <= 1'b1;
		opCode <= c;
		addrMode <= m;
		opWord <= w;
		regDst <= r;
		regSrc <= r;
		extWord <= x;
		{bitNum, halfCarry, carryIn, regDstUpper, regSrcUpper} <= f;
		@(posedge core_clk);
		opValid <= 1'b0;
		#1;
		n = 0;
		while (opDone !== 1'b1 && opIllegal !== 1'b1 && n < 10)
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
		`CHK(n < 10, 1'b1, "no completion")
		@(posedge core_clk);
	endtask : op
	always @(negedge core_clk)
	begin
		if (memReq === 1'b1 || opIllegal === 1'b1)
		begin
			if (expQ.size() == 0)
				`CHK(1'b0, 1'b1, "unexpected result")
			else
			begin
				e = expQ.pop_front();
				`CHK({opIllegal, memReq}, {e[34], ~e[34]}, "result kind")
				if (!e[34])
				begin
					`CHK({memWrite, memWord, memAddr}, e[33:16], "access")
					if (e[33])
						`CHK(memWdata, e[15:0], "write data")
				end
			end
		end
	end
	initial
	begin
		#200000;
		err_total++;
		tally_and_finish();
	end
	initial
	begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		sp = ($random(seed) & 16'h7ffe) | 16'h0100;
		v = $random(seed);
		op(ofx_pkg::OFX_OP_TRANSFER, ofx_pkg::OFX_AM_IMM, 1'b1, ofx_pkg::STACK_REG_IDX, sp);
		op(ofx_pkg::OFX_OP_TRANSFER, ofx_pkg::OFX_AM_IMM, 1'b1, 3'h1, v);
		exp(1'b0, 1'b1, 1'b1, sp - 16'h0002, v);
		op(ofx_pkg::OFX_OP_PUSH, ofx_pkg::OFX_AM_PREDEC, 1'b1, 3'h1, 16'h0000);
		exp(1'b0, 1'b0, 1'b1, sp - 16'h0002, 16'h0000);
		op(ofx_pkg::OFX_OP_POP, ofx_pkg::OFX_AM_POSTINC, 1'b1, 3'h2, 16'h0000);
		exp(1'b0, 1'b1, 1'b1, sp - 16'h0002, v);
		op(ofx_pkg::OFX_OP_PUSH, ofx_pkg::OFX_AM_PREDEC, 1'b1, 3'h2, 16'h0000);
		exp(1'b0, 1'b0, 1'b1, sp - 16'h0002, 16'h0000);
		op(ofx_pkg::OFX_OP_FLAGS_POP, ofx_pkg::OFX_AM_POSTINC, 1'b1, 3'h0, 16'h0000);
		`CHK(condFlags, v[15:8], "restored flags")
		exp(1'b0, 1'b1, 1'b1, sp - 16'h0002, {v[15:8], v[15:8]});
		op(ofx_pkg::OFX_OP_FLAGS_PUSH, ofx_pkg::OFX_AM_PREDEC, 1'b1, 3'h0, 16'h0000);
		for (int k = 0; k < 2; k++)
		begin
			a = $random(seed);
			v = $random(seed) | 16'h0001;
			op(ofx_pkg::OFX_OP_TRANSFER, ofx_pkg::OFX_AM_IMM, 1'b1, 3'h5, a);
			exp(1'b0, 1'b0, 1'b1, (a + (k ? v : 16'h0000)) & 16'hfffe, 16'h0000);
			op(ofx_pkg::OFX_OP_TRANSFER, k ? ofx_pkg::OFX_AM_DISP : ofx_pkg::OFX_AM_IND, 1'b1, 3'h5, v);
		end
		a = $random(seed) | 16'h0001;
		exp(1'b0, 1'b0, 1'b1, a & 16'hfffe, 16'h0000);
		op(ofx_pkg::OFX_OP_TRANSFER, ofx_pkg::OFX_AM_ABS16, 1'b1, 3'h3, a);
		exp(1'b0, 1'b0, 1'b0, a, 16'h0000);
		op(ofx_pkg::OFX_OP_TRANSFER, ofx_pkg::OFX_AM_ABS16, 1'b0, 3'h3, a);
		exp(1'b0, 1'b0, 1'b0, ofx_pkg::SHORT_PAGE_BASE | {8'h00, a[7:0]}, 16'h0000);
		op(ofx_pkg::OFX_OP_TRANSFER, ofx_pkg::OFX_AM_ABS8, 1'b0, 3'h3, a);
		exp(1'b1, 1'b0, 1'b0, 16'h0000, 16'h0000);
		op(ofx_pkg::OFX_OP_TRANSFER, ofx_pkg::OFX_AM_ABS8, 1'b1, 3'h3, a);
		exp(1'b1, 1'b0, 1'b0, 16'h0000, 16'h0000);
		op(ofx_pkg::OFX_OP_PERIPH_OUT, ofx_pkg::OFX_AM_ABS16, 1'b0, 3'h3, a);
		exp(1'b1, 1'b0, 1'b0, 16'h0000, 16'h0000);
		op(ofx_pkg::OFX_OP_PERIPH_IN, ofx_pkg::OFX_AM_ABS16, 1'b0, 3'h3, a);
		t = $random(seed);
		op(ofx_pkg::OFX_OP_TRANSFER, ofx_pkg::OFX_AM_IMM, 1'b1, 3'h6, {t, t});
		exp(1'b0, 1'b1, 1'b0, {t, t} - 16'h0001, {t, t});
		op(ofx_pkg::OFX_OP_TRANSFER, ofx_pkg::OFX_AM_PREDEC, 1'b0, 3'h6, 16'h0000);
		exp(1'b0, 1'b0, 1'b0, {t, t} - 16'h0001, 16'h0000);
		op(ofx_pkg::OFX_OP_TRANSFER, ofx_pkg::OFX_AM_POSTINC, 1'b0, 3'h6, 16'h0000);
		b = $random(seed);
		op(ofx_pkg::OFX_OP_TRANSFER, ofx_pkg::OFX_AM_IMM, 1'b1, 3'h4, b);
		op(ofx_pkg::OFX_OP_BIT_SET, ofx_pkg::OFX_AM_REG, 1'b0, 3'h4, 16'h0000);
		b = b | (16'h0001 << {f[1], f[6:4]});
		op(ofx_pkg::OFX_OP_BIT_CLR, ofx_pkg::OFX_AM_REG, 1'b0, 3'h4, 16'h0000);
		b = b & ~(16'h0001 << {f[1], f[6:4]});
		op(ofx_pkg::OFX_OP_DEC_ADJ_ADD, ofx_pkg::OFX_AM_REG, 1'b0, 3'h4, 16'h0000);
		t = f[1] ? b[15:8] : b[7:0];
		t = t + ((f[3] || t[3:0] > 4'h9) ? 8'h06 : 8'h00) + ((f[2] || t > 8'h99) ? 8'h60 : 8'h00);
		b = f[1] ? {t, b[7:0]} : {b[15:8], t};
		op(ofx_pkg::OFX_OP_DEC_ADJ_SUB, ofx_pkg::OFX_AM_REG, 1'b0, 3'h4, 16'h0000);
		t = (f[1] ? b[15:8] : b[7:0]) - (f[3] ? 8'h06 : 8'h00) - (f[2] ? 8'h60 : 8'h00);
		b = f[1] ? {t, b[7:0]} : {b[15:8], t};
		op(ofx_pkg::OFX_OP_WORD_SMALL_INC, ofx_pkg::OFX_AM_REG, 1'b0, 3'h4, 16'h0000);
		b = b + (f[5] ? ofx_pkg::WORD_STEP : ofx_pkg::BYTE_STEP);
		op(ofx_pkg::OFX_OP_WORD_SMALL_DEC, ofx_pkg::OFX_AM_REG, 1'b0, 3'h4, 16'h0000);
		b = b - (f[5] ? ofx_pkg::WORD_STEP : ofx_pkg::BYTE_STEP);
		exp(1'b0, 1'b1, 1'b1, sp - 16'h0004, b);
		op(ofx_pkg::OFX_OP_PUSH, ofx_pkg::OFX_AM_PREDEC, 1'b1, 3'h4, 16'h0000);
		repeat (3) @(posedge core_clk);
		`CHK(expQ.size(), 0, "missing results")
		tally_and_finish();
	end
endmodule : tb
